// File: verilog/uvep_pkg.sv
// constants, timing and types for the uv eprom host controller
package uvep_pkg;

  // array shape, timer and monitor widths
  localparam int ADDR_W      = 9;
  localparam int DATA_W      = 8;
  localparam int ARRAY_BITS  = 4096;
  localparam int WORDS       = ARRAY_BITS / DATA_W;
  localparam int TMR_W       = 22;
  localparam int MON_W       = 32;

  // clock and unit scaling
  localparam int T_CLK_NS    = 10;
  localparam int NS_PER_US   = 1000;
  localparam int NS_PER_MS   = 1000000;

  // read cycle times, slowest grade
  localparam int T_ACC_NS    = 600;
  localparam int T_DIS_NS    = 150;
  localparam int T_STRH_NS   = 150;
  localparam int T_ASET_NS   = 0;
  localparam int T_AHOLD_NS  = 100;

  // program cycle times, duty limit and retry count
  localparam int T_DSET_US   = 9;
  localparam int T_DHOLD_US  = 9;
  localparam int T_RAMP_US   = 10;
  localparam int T_PULSE_MS  = 20;
  localparam int T_PMIN_MS   = 18;
  localparam int DUTY_PCT    = 75;
  localparam int FULL_PCT    = 100;
  localparam int TRIES_DEF   = 25;

  // least time to whole cycles, rounded up, never below one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + T_CLK_NS - 1) / T_CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  localparam int ACC_CYC     = ns_to_cyc(T_ACC_NS);
  localparam int REL_CYC     = max2(ns_to_cyc(T_DIS_NS), ns_to_cyc(T_STRH_NS));
  localparam int ASET_CYC    = ns_to_cyc(T_ASET_NS);
  localparam int AHOLD_CYC   = ns_to_cyc(T_AHOLD_NS);
  localparam int DSET_CYC    = ns_to_cyc(T_DSET_US * NS_PER_US);
  localparam int DHOLD_CYC   = ns_to_cyc(T_DHOLD_US * NS_PER_US);
  localparam int RAMP_CYC    = ns_to_cyc(T_RAMP_US * NS_PER_US);
  localparam int PULSE_NOM   = ns_to_cyc(T_PULSE_MS * NS_PER_MS);

  // controller states, one-hot
  typedef enum logic [9:0] {
    ST_IDLE    = 10'h001,
    ST_SETUP   = 10'h002,
    ST_ACCESS  = 10'h004,
    ST_RELEASE = 10'h008,
    ST_DSETUP  = 10'h010,
    ST_RAMPDN  = 10'h020,
    ST_PULSE   = 10'h040,
    ST_RAMPUP  = 10'h080,
    ST_DHOLD   = 10'h100,
    ST_COOL    = 10'h200
  } uvep_state_t;

endpackage

// File: verilog/uvep_tmr_if.sv
// wait timer link between controller and its interval counter
`timescale 1ns/1ps
interface uvep_tmr_if;
  import uvep_pkg::*;
  logic             load;
  logic [TMR_W-1:0] value;
  logic             expired;

  modport ctrl (output load, output value, input expired);
  modport tmr  (input load, input value, output expired);
endinterface

// File: verilog/uvep_timer.sv
// down counter that times every wait of the controller
`timescale 1ns/1ps
module uvep_timer
  import uvep_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic rst_i,
  uvep_tmr_if.tmr   tmr
);

  logic [TMR_W-1:0] count;

  // load takes the interval, then count down to zero and rest there
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      count <= '0;
    end else if (tmr.load) begin
      count <= tmr.value;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign tmr.expired = (count == '0) && !tmr.load;

endmodule // uvep_timer

// File: verilog/uvep_host.sv
// host controller that reads and programs a strobe-latched uv eprom
`timescale 1ns/1ps

// Operation
// - program cycle addresses the word exactly like a read cycle.
// - programming pulse nominally 20 ms, never under 18 ms.
// - programming pulse duty cycle stays at or below 75 percent.
// - pulse edges ramp no faster than 5 us; 10 us used.
// - write data stable 9 us before and after each pulse.
// - use read, program, verify loops per word, not blind pulses.
// - address and enable valid at strobe fall, held 100 ns after.
// - programming input stays inactive for the whole read cycle.
// - strobe high at least 150 ns before next falling edge.
// - strobe low at least the access time before it rises.
module uvep_host
  import uvep_pkg::*;
#(
  parameter int PULSE_CYC = PULSE_NOM,
  parameter int MAX_TRIES = TRIES_DEF
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire logic              req_i,
  input  wire logic              prog_cmd_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  output logic                   ready_o,
  output logic                   done_o,
  output logic                   fail_o,
  output logic      [DATA_W-1:0] rdata_o,
  output logic                   address_strobe_n_o,
  output logic                   latched_chip_enable_n_o,
  output logic                   output_select_n_o,
  output logic      [ADDR_W-1:0] word_address_lines_o,
  input  wire logic [DATA_W-1:0] data_lines_i,
  output logic      [DATA_W-1:0] data_lines_o,
  output logic                   data_lines_oe_o,
  output logic                   prog_pulse_o
);

  // off time needed so that on time stays within the duty limit
  localparam int ON_CYC    = PULSE_CYC + 2 * RAMP_CYC + 2;
  localparam int RECOV_CYC = (ON_CYC * (FULL_PCT - DUTY_PCT) + DUTY_PCT - 1) / DUTY_PCT + 1;
  localparam int PMIN_CYC  = (PULSE_CYC * T_PMIN_MS) / T_PULSE_MS;
  localparam int TRY_W     = $clog2(MAX_TRIES + 1);

  uvep_state_t      state;
  uvep_tmr_if       tmr_bus ();
  logic             is_prog;
  logic             prog_phase;
  logic [DATA_W-1:0] wdata;
  logic [TRY_W-1:0] tries;
  logic             tmr_load;
  logic [TMR_W-1:0] tmr_value;

  function automatic logic [TMR_W-1:0] tval(input int cyc);
    return TMR_W'(cyc);
  endfunction

  // word needs a bit raised, which no pulse can do
  function automatic logic needs_raise(input logic [DATA_W-1:0] have,
                                       input logic [DATA_W-1:0] want);
    return |(~have & want);
  endfunction

  uvep_timer u_timer (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .tmr    (tmr_bus.tmr)
  );

  assign tmr_bus.load  = tmr_load;
  assign tmr_bus.value = tmr_value;
  assign ready_o       = (state == ST_IDLE);

  // sequencer: read cycle, then for programs pulse and verify loops
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state      <= ST_IDLE;
      is_prog    <= 1'b0;
      prog_phase <= 1'b0;
      tries      <= '0;
      tmr_load   <= 1'b0;
      tmr_value  <= '0;
    end else begin
      tmr_load <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (req_i) begin // any address, any order
            is_prog    <= prog_cmd_i;
            prog_phase <= 1'b0;
            tries      <= '0;
            tmr_load   <= 1'b1;
            tmr_value  <= tval(ASET_CYC);
            state      <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (tmr_bus.expired) begin
            tmr_load  <= 1'b1;
            tmr_value <= prog_phase ? tval(DSET_CYC) : tval(ACC_CYC);
            state     <= prog_phase ? ST_DSETUP : ST_ACCESS; // same latch as read
          end
        end
        ST_ACCESS: begin
          if (tmr_bus.expired) begin // strobe low for the access time
            tmr_load  <= 1'b1;
            tmr_value <= tval(REL_CYC);
            state     <= ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          if (tmr_bus.expired) begin // strobe high and outputs floated
            if (!is_prog || rdata_o == wdata || needs_raise(rdata_o, wdata) ||
                tries == TRY_W'(MAX_TRIES)) begin
              state <= ST_IDLE;
            end else begin // verify failed, pulse again
              prog_phase <= 1'b1;
              tmr_load   <= 1'b1;
              tmr_value  <= tval(ASET_CYC);
              state      <= ST_SETUP;
            end
          end
        end
        ST_DSETUP: begin
          if (tmr_bus.expired) begin // data set before the pulse
            tmr_load  <= 1'b1;
            tmr_value <= tval(RAMP_CYC);
            state     <= ST_RAMPDN;
          end
        end
        ST_RAMPDN: begin
          if (tmr_bus.expired) begin // falling edge slews outside
            tmr_load  <= 1'b1;
            tmr_value <= tval(PULSE_CYC);
            state     <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          if (tmr_bus.expired) begin // full pulse width
            tmr_load  <= 1'b1;
            tmr_value <= tval(RAMP_CYC);
            state     <= ST_RAMPUP;
          end
        end
        ST_RAMPUP: begin
          if (tmr_bus.expired) begin // rising edge slews outside
            tmr_load  <= 1'b1;
            tmr_value <= tval(DHOLD_CYC);
            state     <= ST_DHOLD;
          end
        end
        ST_DHOLD: begin
          if (tmr_bus.expired) begin // data held after the pulse
            tries     <= tries + 1'b1;
            tmr_load  <= 1'b1;
            tmr_value <= tval(RECOV_CYC);
            state     <= ST_COOL;
          end
        end
        ST_COOL: begin
          if (tmr_bus.expired) begin // off time keeps duty in bounds
            prog_phase <= 1'b0;
            tmr_load   <= 1'b1;
            tmr_value  <= tval(ASET_CYC);
            state      <= ST_SETUP;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // address and enable presented before the strobe falls, kept until idle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      word_address_lines_o    <= '0;
      latched_chip_enable_n_o <= 1'b1;
      wdata                   <= '1;
    end else if (state == ST_IDLE && req_i) begin // valid ahead of the fall
      word_address_lines_o    <= addr_i;
      latched_chip_enable_n_o <= 1'b0;
      wdata                   <= wdata_i;
    end else if (state == ST_IDLE) begin
      latched_chip_enable_n_o <= 1'b1;
    end
  end

  // strobe low from the end of setup until access ends, or until data hold ends when programming
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      address_strobe_n_o <= 1'b1;
    end else if (state == ST_SETUP && tmr_bus.expired) begin
      address_strobe_n_o <= 1'b0; // latching edge
    end else if ((state == ST_ACCESS || state == ST_DHOLD) && tmr_bus.expired) begin
      address_strobe_n_o <= 1'b1;
    end
  end

  // output select only in read phases, never while programming
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      output_select_n_o <= 1'b1;
    end else if (state == ST_SETUP && tmr_bus.expired && !prog_phase) begin
      output_select_n_o <= 1'b0; // read phases only, pulse pin idle
    end else if (state == ST_ACCESS && tmr_bus.expired) begin
      output_select_n_o <= 1'b1;
    end
  end

  // sample read data at the end of the access time
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (state == ST_ACCESS && tmr_bus.expired) begin
      rdata_o <= data_lines_i;
    end
  end

  // write data driven only while the device outputs are off
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      data_lines_o    <= '0;
      data_lines_oe_o <= 1'b0;
    end else if (state == ST_SETUP && tmr_bus.expired && prog_phase) begin
      data_lines_o    <= wdata; // levels the pulse writes
      data_lines_oe_o <= 1'b1;
    end else if (state == ST_DHOLD && tmr_bus.expired) begin
      data_lines_oe_o <= 1'b0;
    end
  end

  // programming pin active from ramp down through pulse end
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      prog_pulse_o <= 1'b0;
    end else if (state == ST_DSETUP && tmr_bus.expired) begin
      prog_pulse_o <= 1'b1;
    end else if (state == ST_PULSE && tmr_bus.expired) begin
      prog_pulse_o <= 1'b0;
    end
  end

  // completion pulse and verdict
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      fail_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (state == ST_RELEASE && tmr_bus.expired) begin
        if (!is_prog || rdata_o == wdata) begin
          done_o <= 1'b1;
          fail_o <= 1'b0;
        end else if (needs_raise(rdata_o, wdata) || tries == TRY_W'(MAX_TRIES)) begin
          done_o <= 1'b1; // zero to one impossible, or out of tries
          fail_o <= 1'b1;
        end
      end
    end
  end

  // pin monitors used only by the checks below
  logic [MON_W-1:0] low_cnt;
  logic [MON_W-1:0] high_cnt;
  logic [MON_W-1:0] pon_cnt;
  logic [MON_W-1:0] poff_cnt;
  logic [MON_W-1:0] last_on;
  logic [MON_W-1:0] oe_cnt;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      low_cnt  <= '0;
      high_cnt <= '1;
    end else if (address_strobe_n_o) begin
      low_cnt  <= '0;
      high_cnt <= (high_cnt == '1) ? high_cnt : high_cnt + 1'b1;
    end else begin
      high_cnt <= '0;
      low_cnt  <= (low_cnt == '1) ? low_cnt : low_cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pon_cnt  <= '0;
      poff_cnt <= '1;
      last_on  <= '0;
      oe_cnt   <= '0;
    end else begin
      pon_cnt  <= prog_pulse_o ? pon_cnt + 1'b1 : '0;
      poff_cnt <= prog_pulse_o ? '0 : ((poff_cnt == '1) ? poff_cnt : poff_cnt + 1'b1);
      if (prog_pulse_o) begin
        last_on <= pon_cnt + 1'b1;
      end
      oe_cnt <= data_lines_oe_o ? oe_cnt + 1'b1 : '0;
    end
  end

  property p_addr_hold;
    @(posedge mclk_i) disable iff (rst_i)
    !address_strobe_n_o |-> $stable(word_address_lines_o) && $stable(latched_chip_enable_n_o);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved under low strobe");

  property p_strobe_low;
    @(posedge mclk_i) disable iff (rst_i)
    $rose(address_strobe_n_o) |-> (low_cnt >= MON_W'(ACC_CYC));
  endproperty
  a_strobe_low: assert property (p_strobe_low) else $error("strobe low too short");

  property p_strobe_high;
    @(posedge mclk_i) disable iff (rst_i)
    $fell(address_strobe_n_o) |-> (high_cnt >= MON_W'(ns_to_cyc(T_STRH_NS)));
  endproperty
  a_strobe_high: assert property (p_strobe_high) else $error("strobe high too short");

  property p_no_prog_in_read;
    @(posedge mclk_i) disable iff (rst_i)
    !output_select_n_o |-> !prog_pulse_o ##1 !prog_pulse_o;
  endproperty
  a_no_prog_in_read: assert property (p_no_prog_in_read) else $error("pulse during read");

  property p_prog_addressed;
    @(posedge mclk_i) disable iff (rst_i)
    prog_pulse_o |-> !address_strobe_n_o && !latched_chip_enable_n_o && data_lines_oe_o;
  endproperty
  a_prog_addressed: assert property (p_prog_addressed) else $error("pulse without latched word");

  property p_pulse_width;
    @(posedge mclk_i) disable iff (rst_i)
    $fell(prog_pulse_o) |-> (pon_cnt >= MON_W'(PMIN_CYC));
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("programming pulse too short");

  property p_duty;
    @(posedge mclk_i) disable iff (rst_i)
    $rose(prog_pulse_o) |-> (poff_cnt * DUTY_PCT >= last_on * (FULL_PCT - DUTY_PCT));
  endproperty
  a_duty: assert property (p_duty) else $error("pulse duty cycle exceeded");

  property p_data_setup;
    @(posedge mclk_i) disable iff (rst_i)
    $rose(prog_pulse_o) |-> (oe_cnt >= MON_W'(DSET_CYC)) && $stable(data_lines_o);
  endproperty
  a_data_setup: assert property (p_data_setup) else $error("data setup before pulse short");

  property p_data_hold;
    @(posedge mclk_i) disable iff (rst_i)
    $fell(data_lines_oe_o) |-> (poff_cnt >= MON_W'(DHOLD_CYC)) && !prog_pulse_o;
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data hold after pulse short");

endmodule // uvep_host

// File: sim/uvep_eprom_model.sv
// behavioural model of the strobe-latched uv eprom on the far side
`timescale 1ns/1ps
module uvep_eprom_model
  import uvep_pkg::*;
(
  input  wire logic              address_strobe_n_i,
  input  wire logic              latched_chip_enable_n_i,
  input  wire logic              output_select_n_i,
  input  wire logic [ADDR_W-1:0] word_address_lines_i,
  input  wire logic [DATA_W-1:0] data_lines_i,
  input  wire logic              prog_pulse_i,
  input  wire logic              fast_i,
  input  wire logic [DATA_W-1:0] stuck_i,
  output logic      [DATA_W-1:0] data_lines_o,
  output logic                   data_lines_oe_o
);
  logic    [DATA_W-1:0] mem [WORDS];  // 512 words of eight bits
  logic    [ADDR_W-1:0] lat_addr;
  logic                 lat_en_n;
  logic                 on;
  realtime              t_fall;
  realtime              t_off;

  // erased array reads all ones
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    lat_addr = '0;
    lat_en_n = 1'b1;
    t_fall = 0;
    t_off = -1000;
    data_lines_o = 8'h00;
    data_lines_oe_o = 1'b0;
  end

  // address and enable captured on strobe fall
  always @(negedge address_strobe_n_i) begin
    lat_addr = word_address_lines_i;
    lat_en_n = latched_chip_enable_n_i;
    t_fall = $realtime;
  end

  // pulse writes held levels, only ones to zeros, any word
  always @(posedge prog_pulse_i) begin
    if (!lat_en_n && !address_strobe_n_i)
      mem[lat_addr] = mem[lat_addr] & (data_lines_i | stuck_i);
  end

  // drivers follow strobe and select; deselect floats
  always begin
    #1;
    on = !address_strobe_n_i && !output_select_n_i && !lat_en_n;
    if (on) begin
      data_lines_oe_o = 1'b1;  // active ahead of valid data
      if ($realtime - t_fall >= (fast_i ? 450.0 : 600.0))
        data_lines_o = mem[lat_addr];  // valid within access time
      else
        data_lines_o = ~data_lines_o;  // not yet valid, keeps changing
      t_off = $realtime;
    end else if ($realtime - t_off >= (fast_i ? 100.0 : 140.0)) begin
      if (data_lines_oe_o)
        data_lines_o = ~data_lines_o;  // floated line shows inverse
      data_lines_oe_o = 1'b0;
    end
  end
endmodule  // uvep_eprom_model

// File: sim/uvep_host_tb.sv
// self-checking bench for the uv eprom host controller
`timescale 1ns/1ps
module uvep_host_tb;
  import uvep_pkg::*;
  localparam int PULSE_T = 200;
  localparam int TRIES_T = 3;
  localparam int ACC_C   = T_ACC_NS / T_CLK_NS;
  localparam int STRH_C  = T_STRH_NS / T_CLK_NS;
  localparam int AHOLD_C = T_AHOLD_NS / T_CLK_NS;
  localparam int DSET_C  = T_DSET_US * NS_PER_US / T_CLK_NS;
  localparam int DHOLD_C = T_DHOLD_US * NS_PER_US / T_CLK_NS;
  localparam int EDGE_C  = 5 * NS_PER_US / T_CLK_NS;
  localparam int BIG     = 1000000;

  logic              mclk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              req = 1'b0, prog_cmd = 1'b0, fast = 1'b0;
  logic [ADDR_W-1:0] addr = '0, wal, la;
  logic [DATA_W-1:0] wdata = '0, stuck = '0, rdata, dlo, dev_q, dp;
  logic              ready, done, fail, strobe_n, en_n, sel_n, doe, prog, dev_oe;
  logic              sp, pp, op;
  wire  [DATA_W-1:0] bus = dev_oe ? dev_q : (doe ? dlo : dev_q);
  int                n_fail = 0, tests_run = 0;
  int                lo_c, hi_c, on_c, off_c, pf_c, ds_c, last_on, pulses = 0;

  uvep_host #(.PULSE_CYC(PULSE_T), .MAX_TRIES(TRIES_T)) dut_u (
    .mclk_i(mclk_i), .rst_i(rst_i), .req_i(req), .prog_cmd_i(prog_cmd), .addr_i(addr),
    .wdata_i(wdata), .ready_o(ready), .done_o(done), .fail_o(fail), .rdata_o(rdata),
    .address_strobe_n_o(strobe_n), .latched_chip_enable_n_o(en_n),
    .output_select_n_o(sel_n), .word_address_lines_o(wal), .data_lines_i(bus),
    .data_lines_o(dlo), .data_lines_oe_o(doe), .prog_pulse_o(prog));

  uvep_eprom_model dev_u (
    .address_strobe_n_i(strobe_n), .latched_chip_enable_n_i(en_n),
    .output_select_n_i(sel_n), .word_address_lines_i(wal), .data_lines_i(bus),
    .prog_pulse_i(prog), .fast_i(fast), .stuck_i(stuck), .data_lines_o(dev_q),
    .data_lines_oe_o(dev_oe));

  // free-running clock
  always #5 mclk_i = ~mclk_i;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("n_fail=%0d tests_run=%0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // pin timing watch, sampled on the falling clock edge where pins are settled
  always @(negedge mclk_i) begin
    if (rst_i) begin
      lo_c = 0; hi_c = BIG; off_c = BIG; pf_c = BIG; ds_c = 0; last_on = 0;
      sp = 1'b1; pp = 1'b0; op = 1'b0; dp = '0; on_c = 0;
    end else begin
      if (sp && !strobe_n) begin
        check(32'(hi_c >= STRH_C), 32'h1);
        check(32'(en_n), 32'h0);
        la = wal;
        lo_c = 0;
      end
      if (!sp && strobe_n) check(32'(lo_c >= ACC_C), 32'h1);
      if (!strobe_n && lo_c == AHOLD_C) check(32'(wal), 32'(la));
      if (!pp && prog) begin
        check(32'(ds_c >= DSET_C), 32'h1);
        check(32'(off_c * DUTY_PCT >= last_on * (FULL_PCT - DUTY_PCT)), 32'h1);
        on_c = 0;
        pulses++;
      end
      if (pp && !prog) begin
        check(32'(on_c >= PULSE_T * T_PMIN_MS / T_PULSE_MS + EDGE_C), 32'h1);
        last_on = on_c;
        off_c = 0;
        pf_c = 0;
      end
      if (op && !doe) check(32'(pf_c >= DHOLD_C && ds_c > pf_c), 32'h1);
      if (prog && !sel_n) check(32'h0, 32'h1);
      if (doe && dev_oe) check(32'h0, 32'h1);
      ds_c = (!doe || dlo !== dp) ? 0 : ds_c + 1;
      lo_c = strobe_n ? 0 : lo_c + 1;
      hi_c = strobe_n ? hi_c + 1 : 0;
      on_c = on_c + 1;
      off_c = off_c + 1;
      pf_c = pf_c + 1;
      sp = strobe_n; pp = prog; op = doe; dp = dlo;
    end
  end

  // one user command, held until taken, then waits for completion
  task automatic cmd(input logic p, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    while (ready !== 1'b1) begin
      @(posedge mclk_i);
      #1;
    end
    req = 1'b1; prog_cmd = p; addr = a; wdata = d;
    @(posedge mclk_i);
    #1;
    req = 1'b0;
    while (done !== 1'b1 && n < 30000) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    if (n >= 30000) check(32'h0, 32'h1);
  endtask

  task automatic s_reset;
    check(32'({strobe_n, en_n, sel_n, doe, prog, ready, done}), 32'h72);
  endtask

  task automatic s_erased;
    cmd(1'b0, 9'h000, 8'h00); check(32'(rdata), 32'hff);
    cmd(1'b0, 9'h1ff, 8'h00); check(32'(rdata), 32'hff);
  endtask

  task automatic s_prog;
    int p0;
    p0 = pulses;
    cmd(1'b1, 9'h1ff, 8'ha5); check(32'(fail), 32'h0);
    check(32'(pulses - p0), 32'h1);
    cmd(1'b0, 9'h1ff, 8'h00); check(32'(rdata), 32'ha5);
    cmd(1'b1, 9'h000, 8'h3c); check(32'(fail), 32'h0);
    cmd(1'b0, 9'h000, 8'h00); check(32'(rdata), 32'h3c);
    cmd(1'b0, 9'h100, 8'h00); check(32'(rdata), 32'hff);
  endtask

  task automatic s_same_and_up;
    int p0;
    p0 = pulses;
    cmd(1'b1, 9'h000, 8'h3c); check(32'(fail), 32'h0);
    cmd(1'b1, 9'h1ff, 8'h5a); check(32'(fail), 32'h1);
    check(32'(pulses - p0), 32'h0);
    cmd(1'b0, 9'h1ff, 8'h00); check(32'(rdata), 32'ha5);
  endtask

  task automatic s_stuck;
    int p0;
    p0 = pulses;
    stuck = 8'h01;
    cmd(1'b1, 9'h055, 8'hfe); check(32'(fail), 32'h1);
    check(32'(pulses - p0), 32'(TRIES_T));
    check(32'(rdata), 32'hff);
    stuck = 8'h00;
    cmd(1'b1, 9'h055, 8'hfe); check(32'(fail), 32'h0);
    cmd(1'b0, 9'h055, 8'h00); check(32'(rdata), 32'hfe);
  endtask

  task automatic s_fast;
    fast = 1'b1;
    cmd(1'b0, 9'h1ff, 8'h00); check(32'(rdata), 32'ha5);
    cmd(1'b0, 9'h000, 8'h00); check(32'(rdata), 32'h3c);
    fast = 1'b0;
  endtask

  // main sequence
  initial begin
    repeat (2) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    s_reset();
    s_erased();
    s_prog();
    s_same_and_up();
    s_stuck();
    s_fast();
    give_verdict();
  end

  // hang guard, well beyond the expected run length
  initial begin
    repeat (80000) @(posedge mclk_i);
    n_fail++;
    give_verdict();
  end
endmodule  // uvep_host_tb
